// ---- link_partner_model.sv ----
// Far-end model: cable, remote link partner and transmit medium.
// Assumes mclk_i timing; plug_i says whether a cable is attached.
`timescale 1ns/100ps
module link_partner_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic plug_i,
  input wire logic link_pulse_en_i,
  input wire logic tx_start_i,
  output logic energy_o,
  output logic link_o,
  output logic tx_done_o
);
  logic [2:0] dly_reg;
  // ----------------------------------------
  // Medium
  // ----------------------------------------
  // Partner only links once our pulses reach it
  assign energy_o = plug_i;
  assign link_o = plug_i & link_pulse_en_i;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_reg <= 3'h0;
      tx_done_o <= 1'b0;
    end else begin
      tx_done_o <= (dly_reg == 3'h1);
      if (tx_start_i && dly_reg == 3'h0 && !tx_done_o) begin
        dly_reg <= 3'h4;
      end else if (dly_reg != 3'h0) begin
        dly_reg <= dly_reg - 3'h1;
      end
    end
  end
endmodule : link_partner_model

// ---- phy_ed_control.sv ----
// PHY energy-detect control register with APB slave and interrupt.
// Assumes APB master in mclk_i domain; PHY analog signals synchronous.
// How it works
// - With sleep enable set the PHY powers down without energy and up with it; clear keeps it on.
// - The threshold select output lowers the wake energy level when set.
// - Force link reports link up at once, only while powered and running at 100 Mbps.
// - The energy flag is read-only, resets to one and reflects energy on the receive pair.
// - Reserved bits are ignored on write and read as zero; writable bits reset to zero.
// - The energy flag is set whenever a signal is seen on the medium.
// - Asleep and unlinked, a transmit request stays pending with no done interrupt.
// - Asleep, link pulses are suppressed and the PHY only listens.
`timescale 1ns/100ps
module phy_ed_control (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic energy_detect_i,
  input wire logic speed_100_i,
  input wire logic partner_link_i,
  input wire logic tx_done_i,
  output logic phy_powered_o,
  output logic wake_threshold_low_o,
  output logic link_pulse_en_o,
  output logic link_up_o,
  output logic tx_start_o,
  output logic irq_o
);
  logic [15:0] ctrl_reg;
  logic energy_reg;
  logic [phy_ed_pkg::IRQ_W-1:0] irq_status_reg;
  logic [phy_ed_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [phy_ed_pkg::IRQ_W-1:0] irq_event;
  logic tx_request_reg;
  logic link_prev_reg;
  logic link_now;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_next;
  phy_ed_if ed ();

  // ---------------------------------------------
  // Elaboration checks
  // ---------------------------------------------
  // Every field must sit inside the 16-bit register
  if (phy_ed_pkg::BIT_SLEEP_EN >= $bits(ctrl_reg) || phy_ed_pkg::BIT_THRESH >= $bits(ctrl_reg) ||
      phy_ed_pkg::BIT_FORCE_LINK >= $bits(ctrl_reg) || phy_ed_pkg::BIT_ENERGY >= $bits(ctrl_reg)) begin : g_bad_field
    $error("control field outside the register");
  end
  // The status word must hold every event
  if (phy_ed_pkg::IRQ_W <= phy_ed_pkg::IRQ_TX_DONE || phy_ed_pkg::IRQ_W > $bits(ctrl_reg)) begin : g_bad_irq
    $error("interrupt width cannot hold the events");
  end
  // A writable energy flag would let software hide a live status
  if (phy_ed_pkg::CTRL_WRITE_MASK[phy_ed_pkg::BIT_ENERGY]) begin : g_bad_mask
    $error("energy flag marked writable");
  end

  // ---------------------------------------------
  // APB decode
  // ---------------------------------------------
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;

  always_comb begin
    addr_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    if (paddr_i == phy_ed_pkg::OFF_PHY_CONTROL_SECOND) begin
      rdata_next[15:0] = (ctrl_reg & phy_ed_pkg::CTRL_WRITE_MASK);
      rdata_next[phy_ed_pkg::BIT_ENERGY] = energy_reg;
    end else if (paddr_i == phy_ed_pkg::OFF_IRQ_STATUS) begin
      rdata_next[phy_ed_pkg::IRQ_W-1:0] = irq_status_reg;
    end else if (paddr_i == phy_ed_pkg::OFF_IRQ_MASK) begin
      rdata_next[phy_ed_pkg::IRQ_W-1:0] = irq_mask_reg;
    end else if (paddr_i == phy_ed_pkg::OFF_LINK_STATUS) begin
      rdata_next[0] = link_up_o;
      rdata_next[1] = phy_powered_o;
    end else if (paddr_i == phy_ed_pkg::OFF_TX_CONTROL) begin
      rdata_next[0] = tx_request_reg;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read data is a live mux of the registers, so no wait state is needed
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign prdata_o = rdata_next;

  // ---------------------------------------------
  // Control register
  // ---------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= phy_ed_pkg::CTRL_RESET;
    end else if (wr_en && paddr_i == phy_ed_pkg::OFF_PHY_CONTROL_SECOND) begin
      if (pstrb_i[0]) begin
        ctrl_reg[7:0] <= pwdata_i[7:0] & phy_ed_pkg::CTRL_WRITE_MASK[7:0];
      end
      if (pstrb_i[1]) begin
        ctrl_reg[15:8] <= pwdata_i[15:8] & phy_ed_pkg::CTRL_WRITE_MASK[15:8];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      energy_reg <= phy_ed_pkg::ENERGY_RESET;
    end else begin
      energy_reg <= energy_detect_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask_reg <= phy_ed_pkg::IRQ_MASK_RESET;
    end else if (wr_en && paddr_i == phy_ed_pkg::OFF_IRQ_MASK && pstrb_i[0]) begin
      irq_mask_reg <= pwdata_i[phy_ed_pkg::IRQ_W-1:0];
    end
  end

  // ---------------------------------------------
  // Power and link
  // ---------------------------------------------
  assign ed.sleep_en = ctrl_reg[phy_ed_pkg::BIT_SLEEP_EN];
  assign ed.energy = energy_reg;

  phy_ed_power_seq phy_ed_power_seq_inst (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ctl(ed.seq)
  );

  assign phy_powered_o = ed.powered;
  assign wake_threshold_low_o = ctrl_reg[phy_ed_pkg::BIT_THRESH];
  assign link_pulse_en_o = ed.powered;
  // Forcing at 10 Mbps would confuse the partner, so the override is gated
  assign link_now = ed.powered &&
    (partner_link_i || (ctrl_reg[phy_ed_pkg::BIT_FORCE_LINK] && speed_100_i));
  assign link_up_o = link_now;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_prev_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_now;
    end
  end

  // ---------------------------------------------
  // Transmit hold-off
  // ---------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_request_reg <= 1'b0;
    end else if (wr_en && paddr_i == phy_ed_pkg::OFF_TX_CONTROL && pstrb_i[0] && pwdata_i[0]) begin
      // A request written in the finishing cycle wins, so it is not lost
      tx_request_reg <= 1'b1;
    end else if (tx_request_reg && link_now && tx_done_i) begin
      tx_request_reg <= 1'b0;
    end
  end

  // Request waits until a link exists; unlinked it never completes
  assign tx_start_o = tx_request_reg && link_now;

  // ---------------------------------------------
  // Interrupts
  // ---------------------------------------------
  assign irq_event[phy_ed_pkg::IRQ_ENERGY_UP] = energy_detect_i && !energy_reg;
  assign irq_event[phy_ed_pkg::IRQ_LINK_CHANGE] = link_now != link_prev_reg;
  assign irq_event[phy_ed_pkg::IRQ_TX_DONE] = tx_request_reg && link_now && tx_done_i;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status_reg <= '0;
    end else if (rd_en && paddr_i == phy_ed_pkg::OFF_IRQ_STATUS) begin
      irq_status_reg <= irq_event; // Set wins over read clear
    end else begin
      irq_status_reg <= irq_status_reg | irq_event;
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  localparam int WAKE_LAST = phy_ed_pkg::WAKE_CYCLES;
  localparam logic [15:0] CTRL_READ_MASK = phy_ed_pkg::CTRL_WRITE_MASK | (16'h0001 << phy_ed_pkg::BIT_ENERGY);

  // Sleep still enabled, so the disable path cannot pre-empt the wake
  sequence seq_wake_trigger;
    ed.asleep && ed.sleep_en && energy_reg;
  endsequence

  // Held off for the whole settle count, then powered
  sequence seq_wake_run;
    !phy_powered_o ##WAKE_LAST phy_powered_o;
  endsequence

  // A status read with no event in flight must leave the word empty
  sequence seq_quiet_status_read;
    rd_en && paddr_i == phy_ed_pkg::OFF_IRQ_STATUS && irq_event == '0;
  endsequence

  AST_SLEEP_POWER: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ctrl_reg[phy_ed_pkg::BIT_SLEEP_EN] && !energy_reg && phy_powered_o) |=> !phy_powered_o)
    else $error("no power-down on missing energy");
  AST_NO_SLEEP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!ctrl_reg[phy_ed_pkg::BIT_SLEEP_EN] && phy_powered_o) |=> phy_powered_o)
    else $error("power lost while disabled");
  AST_WAKE_TIME: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    seq_wake_trigger |=> seq_wake_run)
    else $error("wake took the wrong time");
  AST_THRESH: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_en && paddr_i == phy_ed_pkg::OFF_PHY_CONTROL_SECOND && pstrb_i[1])
    |=> wake_threshold_low_o == $past(pwdata_i[phy_ed_pkg::BIT_THRESH]))
    else $error("threshold not written");
  AST_FORCE_LINK: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (phy_powered_o && ctrl_reg[phy_ed_pkg::BIT_FORCE_LINK] && speed_100_i) |-> link_up_o)
    else $error("forced link missing");
  AST_FORCE_10: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!speed_100_i && !partner_link_i) |-> !link_up_o)
    else $error("link forced outside 100 Mbps");
  AST_ENERGY_FOLLOW: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    energy_detect_i |=> energy_reg)
    else $error("energy flag not set");
  for (genvar ev = 0; ev < phy_ed_pkg::IRQ_W; ev++) begin : g_sticky
    AST_EVENT_STICKY: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      irq_event[ev] |=> irq_status_reg[ev])
      else $error("event not latched in status");
  end
  AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ctrl_reg & ~phy_ed_pkg::CTRL_WRITE_MASK) == 16'h0000)
    else $error("reserved bit stored");
  AST_RESERVED_READ: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rd_en && paddr_i == phy_ed_pkg::OFF_PHY_CONTROL_SECOND)
    |-> (prdata_o[31:16] == 16'h0000 && (prdata_o[15:0] & ~CTRL_READ_MASK) == 16'h0000))
    else $error("reserved bit read as one");
  AST_TX_HOLD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (tx_request_reg && !link_now) |=> tx_request_reg)
    else $error("transmit request lost while unlinked");
  AST_TX_START_GATED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    tx_start_o |-> link_up_o)
    else $error("transmit started without link");
  AST_TX_IRQ_GATED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!link_now && !irq_status_reg[phy_ed_pkg::IRQ_TX_DONE]) |=> !irq_status_reg[phy_ed_pkg::IRQ_TX_DONE])
    else $error("transmit done raised while unlinked");
  AST_TX_SET: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_en && paddr_i == phy_ed_pkg::OFF_TX_CONTROL && pstrb_i[0] && pwdata_i[0]) |=> tx_request_reg)
    else $error("transmit request not taken");
  AST_NO_PULSE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ed.asleep |-> !link_pulse_en_o)
    else $error("link pulses while asleep");
  AST_LINK_POWER: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !phy_powered_o |-> !link_up_o)
    else $error("link reported while powered down");
  AST_ENERGY_RO: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_en && paddr_i == phy_ed_pkg::OFF_PHY_CONTROL_SECOND) |=> energy_reg == $past(energy_detect_i))
    else $error("energy flag overwritten");
  AST_MASK_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_en && paddr_i == phy_ed_pkg::OFF_IRQ_MASK && pstrb_i[0])
    |=> irq_mask_reg == $past(pwdata_i[phy_ed_pkg::IRQ_W-1:0]))
    else $error("mask not written");
  AST_STATUS_CLEAR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    seq_quiet_status_read |=> irq_status_reg == '0)
    else $error("status not cleared by read");
  AST_UNMAPPED_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_en && !addr_ok) |=> ($stable(ctrl_reg) && $stable(irq_mask_reg)))
    else $error("unmapped write changed a register");
endmodule : phy_ed_control

// ---- phy_ed_if.sv ----
// Bundle between the register file and the power sequencer.
// Assumes both ends share mclk_i.
`timescale 1ns/100ps
interface phy_ed_if;
  logic sleep_en;
  logic energy;
  logic powered;
  logic asleep;
  modport regs (output sleep_en, output energy, input powered, input asleep);
  modport seq (input sleep_en, input energy, output powered, output asleep);
endinterface : phy_ed_if

// ---- phy_ed_pkg.sv ----
// Constants for the PHY energy-detect control block.
// Assumes APB with 32-bit data, one aligned word per register.
package phy_ed_pkg;
  localparam logic [11:0] OFF_PHY_CONTROL_SECOND = 12'h000;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
  localparam logic [11:0] OFF_LINK_STATUS = 12'h00c;
  localparam logic [11:0] OFF_TX_CONTROL = 12'h010;
  localparam int BIT_SLEEP_EN = 13;
  localparam int BIT_THRESH = 11;
  localparam int BIT_FORCE_LINK = 2;
  localparam int BIT_ENERGY = 1;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h2804;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic ENERGY_RESET = 1'b1;
  localparam int IRQ_W = 3;
  localparam int IRQ_ENERGY_UP = 0;
  localparam int IRQ_LINK_CHANGE = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam int WAKE_NS = 100;
  localparam int CLK_NS = 10;
  localparam int WAKE_CYCLES = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {PWR_ON, PWR_SLEEP, PWR_WAKE} pwr_state_type;
endpackage : phy_ed_pkg

// ---- phy_ed_power_seq.sv ----
// Energy-detect power sequencer for the PHY.
// Assumes energy input already filtered and synchronous.
`timescale 1ns/100ps
module phy_ed_power_seq (
  input wire logic mclk_i,
  input wire logic rstn_i,
  phy_ed_if.seq ctl
);
  phy_ed_pkg::pwr_state_type state_reg;
  logic [7:0] wake_cnt_reg;

  // The counter must hold the full settle count
  if (phy_ed_pkg::WAKE_CYCLES < 1 || phy_ed_pkg::WAKE_CYCLES >= (2 ** $bits(wake_cnt_reg))) begin : g_bad_wake
    $error("wake cycle count out of range");
  end

  // ---------------------------------------------
  // Power state
  // ---------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= phy_ed_pkg::PWR_ON;
      wake_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        phy_ed_pkg::PWR_ON: begin
          if (ctl.sleep_en && !ctl.energy) begin
            state_reg <= phy_ed_pkg::PWR_SLEEP;
          end
        end
        phy_ed_pkg::PWR_SLEEP: begin
          if (!ctl.sleep_en) begin
            state_reg <= phy_ed_pkg::PWR_ON;
          end else if (ctl.energy) begin
            state_reg <= phy_ed_pkg::PWR_WAKE;
            wake_cnt_reg <= 8'(phy_ed_pkg::WAKE_CYCLES);
          end
        end
        default: begin
          if (wake_cnt_reg <= 8'h01) begin
            state_reg <= phy_ed_pkg::PWR_ON;
          end
          wake_cnt_reg <= wake_cnt_reg - 8'h01;
        end
      endcase
    end
  end

  assign ctl.powered = (state_reg == phy_ed_pkg::PWR_ON);
  assign ctl.asleep = (state_reg == phy_ed_pkg::PWR_SLEEP);

  AST_SLEEP_EXIT: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_reg == phy_ed_pkg::PWR_SLEEP && !ctl.sleep_en) |=> ctl.powered)
    else $error("sleep not left on disable");
endmodule : phy_ed_power_seq

// ---- phy_energy_detect_control_tb.sv ----
// Self-checking bench for the energy-detect control block.
// Assumes the APB slave answers with pready_o; partner model on the medium.
`timescale 1ns/100ps
module phy_energy_detect_control_tb;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, speed = 1'b0, plug = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, energy, link, txd, powered, thr, pulse_en, link_up, tx_start, irq;
  int fails = 0;
  int n_compared = 0;
  phy_ed_control phy_ed_control_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .energy_detect_i(energy), .speed_100_i(speed),
    .partner_link_i(link), .tx_done_i(txd), .phy_powered_o(powered), .wake_threshold_low_o(thr),
    .link_pulse_en_o(pulse_en), .link_up_o(link_up), .tx_start_o(tx_start), .irq_o(irq));
  link_partner_model link_partner_model_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .plug_i(plug),
    .link_pulse_en_i(pulse_en), .tx_start_i(tx_start), .energy_o(energy), .link_o(link), .tx_done_o(txd));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Read data is taken in the active region of the edge, before register updates land
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fields;
    apb(0, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 0); check("ctrl reset", rd, 32'h2);
    apb(0, phy_ed_pkg::OFF_IRQ_MASK, 0); check("mask reset", rd, 32'h0);
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 32'h0000_2804);
    apb(0, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 0); check("ctrl fields", rd, 32'h2806);
    check("threshold", thr, 1);
    check("awake with energy", powered, 1);
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 0);
    @(posedge mclk_i);
    check("threshold off", thr, 0);
  endtask : t_fields
  task automatic t_sleep;
    apb(1, phy_ed_pkg::OFF_IRQ_MASK, 32'h1);
    apb(0, phy_ed_pkg::OFF_IRQ_STATUS, 0);
    plug <= 1'b0;
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 32'h2002);
    repeat (4) @(posedge mclk_i);
    check("asleep", powered, 0);
    check("no pulses", pulse_en, 0);
    apb(0, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 0); check("flag clear", rd, 32'h2000);
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 0);
    repeat (2) @(posedge mclk_i);
    check("disable wakes", powered, 1);
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 32'h2000);
    repeat (4) @(posedge mclk_i);
    plug <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check("wake delay", powered, 0);
    repeat (40) @(posedge mclk_i);
    check("woken", powered, 1);
    check("irq on energy", irq, 1);
    apb(0, phy_ed_pkg::OFF_IRQ_STATUS, 0); check("energy event", rd & 32'h1, 32'h1);
    @(posedge mclk_i);
    check("irq cleared", irq, 0);
  endtask : t_sleep
  task automatic t_force;
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 32'h4);
    apb(0, phy_ed_pkg::OFF_IRQ_STATUS, 0);
    plug <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("force at 10", link_up, 0);
    apb(0, phy_ed_pkg::OFF_IRQ_STATUS, 0); check("link drop event", rd & 32'h2, 32'h2);
    speed <= 1'b1;
    apb(0, phy_ed_pkg::OFF_LINK_STATUS, 0); check("link status", rd, 32'h3);
    check("force at 100", link_up, 1);
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 0);
    @(posedge mclk_i);
    check("force off", link_up, 0);
    speed <= 1'b0;
  endtask : t_force
  task automatic t_tx;
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 32'h2000);
    apb(1, phy_ed_pkg::OFF_IRQ_MASK, 32'h4);
    apb(0, phy_ed_pkg::OFF_IRQ_STATUS, 0);
    apb(1, phy_ed_pkg::OFF_TX_CONTROL, 32'h1);
    repeat (20) @(posedge mclk_i);
    apb(0, phy_ed_pkg::OFF_TX_CONTROL, 0); check("tx held", rd, 32'h1);
    check("no tx start", tx_start, 0);
    check("no tx irq", irq, 0);
    plug <= 1'b1;
    repeat (40) @(posedge mclk_i);
    apb(0, phy_ed_pkg::OFF_TX_CONTROL, 0); check("tx sent", rd, 32'h0);
    check("tx irq", irq, 1);
  endtask : t_tx
  task automatic t_unmapped;
    apb(1, 12'h100, 32'hffffffff); check("slverr write", err, 1);
    apb(0, 12'h100, 0); check("slverr read", {err, rd[30:0]}, 32'h80000000);
  endtask : t_unmapped
  // Power loss is modelled by a reset in mid-run; the host must set everything up again
  task automatic t_reinit;
    apb(1, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 32'h0000_0804);
    apb(1, phy_ed_pkg::OFF_IRQ_MASK, 32'h7);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    check("irq in reset", irq, 0);
    apb(0, phy_ed_pkg::OFF_PHY_CONTROL_SECOND, 0); check("ctrl after reinit", rd, 32'h2);
    apb(0, phy_ed_pkg::OFF_IRQ_MASK, 0); check("mask after reinit", rd, 32'h0);
    check("powered after reinit", powered, 1);
    check("threshold after reinit", thr, 0);
  endtask : t_reinit
  initial begin
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_fields();
    t_sleep();
    t_force();
    t_tx();
    t_unmapped();
    t_reinit();
    close_out();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    close_out();
  end
endmodule : phy_energy_detect_control_tb
